// ---- src/esoc_regs.vh ----
// Purpose: Register map, reset values and timing counts of the enable
//          sequencing and general output control block.
// Assumes: 250 MHz mclk.
// Notes:   Included by esoc_top.v only.
`ifndef ESOC_REGS_VH
`define ESOC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ESOC_ADDR_REGB_DELAY 8'h0F
`define ESOC_ADDR_OUTA_DELAY 8'h10
`define ESOC_ADDR_OUTB_DELAY 8'h11
`define ESOC_ADDR_OUT_CTRL 8'h12
`define ESOC_ADDR_CONFIG 8'h13

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ESOC_RST_REGB_DELAY 8'h00
`define ESOC_RST_OUTA_DELAY 8'h05
`define ESOC_RST_OUTB_DELAY 8'h0A
`define ESOC_RST_OUT_CTRL 8'h77
`define ESOC_RST_CONFIG 8'h06
`define ESOC_OUT_CTRL_MASK 8'h77

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ESOC_F_A_LEVEL 0
`define ESOC_F_A_GATING 1
`define ESOC_F_A_OD 2
`define ESOC_F_B_LEVEL 4
`define ESOC_F_B_GATING 5
`define ESOC_F_B_OD 6
`define ESOC_F_SPREAD 0
`define ESOC_F_THERMAL 1
`define ESOC_F_ENABLE_PIN_PULLDOWN 2
`define ESOC_F_SHARED_PD 3
`define ESOC_F_SHARED_FN 4
`define ESOC_F_OFF_RANGE 5
`define ESOC_F_ON_RANGE 6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ESOC_CLK_MHZ 250
`define ESOC_STEP_US 500
`define ESOC_STEP_CYCLES (`ESOC_STEP_US * `ESOC_CLK_MHZ)
`define ESOC_CNT_W 23

`endif

// ---- src/esoc_top.v ----
// Purpose: Sequences regulator B and two general outputs from the enable
//          pin and holds the output control and configuration registers.
// Assumes: Register port is the decoded side of the serial interface and
//          runs on mclk; enable pin is asynchronous.
// Notes:   Delays are timed in mclk cycles from the synchronised edge.
`timescale 1ns/1ps
`include "esoc_regs.vh"

module esoc_top #(
	parameter STEP_CYCLES = `ESOC_STEP_CYCLES
)
(
	input wire mclk,
	input wire rst_n,
	input wire enable_pin,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	output reg [7:0] reg_rdata,
	output wire linear_reg_b_en,
	output wire general_output_a_out,
	output wire general_output_a_oe,
	output wire ext_clock_pin_out,
	output wire ext_clock_pin_oe,
	output wire shared_pin_function,
	output wire shared_pin_pulldown,
	output wire enable_pin_pulldown,
	output wire thermal_warn_threshold,
	output wire spread_spectrum_on
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg [7:0] regb_delay;
	reg [7:0] outa_delay;
	reg [7:0] outb_delay;
	reg [7:0] out_ctrl;
	reg [7:0] config_reg;

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			regb_delay <= `ESOC_RST_REGB_DELAY;
			outa_delay <= `ESOC_RST_OUTA_DELAY;
			outb_delay <= `ESOC_RST_OUTB_DELAY;
			out_ctrl <= `ESOC_RST_OUT_CTRL;
			config_reg <= `ESOC_RST_CONFIG;
		end
		else if (reg_we)
		begin
			case (reg_addr)
				`ESOC_ADDR_REGB_DELAY: regb_delay <= reg_wdata;
				`ESOC_ADDR_OUTA_DELAY: outa_delay <= reg_wdata;
				`ESOC_ADDR_OUTB_DELAY: outb_delay <= reg_wdata;
				`ESOC_ADDR_OUT_CTRL:
					out_ctrl <= reg_wdata & `ESOC_OUT_CTRL_MASK;
				`ESOC_ADDR_CONFIG: config_reg <= reg_wdata;
				default: config_reg <= config_reg;
			endcase
		end
	end

	// Unmapped offsets read as zero.
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
		begin
			case (reg_addr)
				`ESOC_ADDR_REGB_DELAY: reg_rdata <= regb_delay;
				`ESOC_ADDR_OUTA_DELAY: reg_rdata <= outa_delay;
				`ESOC_ADDR_OUTB_DELAY: reg_rdata <= outb_delay;
				`ESOC_ADDR_OUT_CTRL: reg_rdata <= out_ctrl;
				`ESOC_ADDR_CONFIG: reg_rdata <= config_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Enable pin synchroniser and edge detect
	// ------------------------------------------------------------------
	reg en_meta;
	reg en_sync;
	reg en_prev;

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_meta <= 1'b0;
			en_sync <= 1'b0;
			en_prev <= 1'b0;
		end
		else
		begin
			en_meta <= enable_pin;
			en_sync <= en_meta;
			en_prev <= en_sync;
		end
	end

	wire en_rise = en_sync & ~en_prev;
	wire en_fall = ~en_sync & en_prev;

	// ------------------------------------------------------------------
	// Delay decode
	// ------------------------------------------------------------------
	// A 1 ms step is two half-millisecond steps, so one step constant
	// serves both ranges.
	function [`ESOC_CNT_W-1:0] esoc_delay_cycles;
		input [3:0] code;
		input wide_range;
		reg [`ESOC_CNT_W-1:0] steps;
		begin
			steps = {{(`ESOC_CNT_W-5){1'b0}}, code, 1'b0};
			if (!wide_range)
				steps = {{(`ESOC_CNT_W-4){1'b0}}, code};
			esoc_delay_cycles = steps * STEP_CYCLES[`ESOC_CNT_W-1:0];
		end
	endfunction

	// ------------------------------------------------------------------
	// Sequencers: channel 0 regulator B, 1 output A, 2 output B
	// ------------------------------------------------------------------
	wire [23:0] codes = {outb_delay, outa_delay, regb_delay};
	wire [2:0] seq_on;

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : chan
			reg state;
			reg pend;
			reg target;
			reg [`ESOC_CNT_W-1:0] cnt;
			wire [`ESOC_CNT_W-1:0] on_load =
				esoc_delay_cycles(codes[8*g+3:8*g],
					config_reg[`ESOC_F_ON_RANGE]);
			wire [`ESOC_CNT_W-1:0] off_load =
				esoc_delay_cycles(codes[8*g+7:8*g+4],
					config_reg[`ESOC_F_OFF_RANGE]);

			// A new edge restarts the wait, so a short enable pulse
			// never leaves an output stuck in the wrong state.
			always @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					state <= 1'b0;
					pend <= 1'b0;
					target <= 1'b0;
					cnt <= {`ESOC_CNT_W{1'b0}};
				end
				else if (en_rise)
				begin
					target <= 1'b1;
					cnt <= on_load;
					pend <= (on_load != {`ESOC_CNT_W{1'b0}});
					if (on_load == {`ESOC_CNT_W{1'b0}})
						state <= 1'b1;
				end
				else if (en_fall)
				begin
					target <= 1'b0;
					cnt <= off_load;
					pend <= (off_load != {`ESOC_CNT_W{1'b0}});
					if (off_load == {`ESOC_CNT_W{1'b0}})
						state <= 1'b0;
				end
				else if (pend)
				begin
					cnt <= cnt - {{(`ESOC_CNT_W-1){1'b0}}, 1'b1};
					if (cnt == {{(`ESOC_CNT_W-1){1'b0}}, 1'b1})
					begin
						state <= target;
						pend <= 1'b0;
					end
				end
			end
			assign seq_on[g] = state;
		end
	endgenerate

	// ------------------------------------------------------------------
	// Output drivers
	// ------------------------------------------------------------------
	assign linear_reg_b_en = seq_on[0];

	wire a_val = out_ctrl[`ESOC_F_A_LEVEL] &
		(~out_ctrl[`ESOC_F_A_GATING] | seq_on[1]);
	wire b_val = out_ctrl[`ESOC_F_B_LEVEL] &
		(~out_ctrl[`ESOC_F_B_GATING] | seq_on[2]);

	// Open-drain only ever pulls low; the pin floats high externally.
	assign general_output_a_out = out_ctrl[`ESOC_F_A_OD] ? 1'b0 : a_val;
	assign general_output_a_oe = ~out_ctrl[`ESOC_F_A_OD] | ~a_val;

	assign shared_pin_function = config_reg[`ESOC_F_SHARED_FN];
	assign ext_clock_pin_out = out_ctrl[`ESOC_F_B_OD] ? 1'b0 : b_val;
	assign ext_clock_pin_oe = ~shared_pin_function &
		(~out_ctrl[`ESOC_F_B_OD] | ~b_val);

	assign shared_pin_pulldown = config_reg[`ESOC_F_SHARED_PD];
	assign enable_pin_pulldown = config_reg[`ESOC_F_ENABLE_PIN_PULLDOWN];
	assign thermal_warn_threshold = config_reg[`ESOC_F_THERMAL];
	assign spread_spectrum_on = config_reg[`ESOC_F_SPREAD];

endmodule

// ---- bench/esoc_host.sv ----
// Purpose: Host side driver of the enable pin.
// Assumes: level changes only on falling mclk.
// Notes:   Pin is always driven, so the pull-down never decides it.
`timescale 1ns/1ps
module esoc_host (
	input wire level,
	output wire enable_pin
);
	assign enable_pin = level;
endmodule

// ---- bench/esoc_top_assertions.sv ----
// Purpose: Port assertions for esoc_top.
// Assumes: Rising mclk, rst_n asynchronous and active low.
// Notes:   Enable edges reach outputs three edges after the pin moves when the delay code is zero.
`timescale 1ns/1ps
module esoc_chk (
	input wire mclk,
	input wire rst_n,
	input wire enable_pin,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire [7:0] reg_rdata,
	input wire linear_reg_b_en,
	input wire general_output_a_out,
	input wire general_output_a_oe,
	input wire ext_clock_pin_out,
	input wire ext_clock_pin_oe,
	input wire shared_pin_function,
	input wire shared_pin_pulldown,
	input wire enable_pin_pulldown,
	input wire thermal_warn_threshold,
	input wire spread_spectrum_on
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire wr12 = reg_we && reg_addr == 8'h12;
	chk_a_push_pull: assert property (wr12 && reg_wdata[2:1] == 2'b00
		|=> general_output_a_out == $past(reg_wdata[0]) && general_output_a_oe)
		else $error("output A push-pull level wrong");
	chk_a_open_drain: assert property (wr12 && reg_wdata[2:1] == 2'b10
		|=> !general_output_a_out && general_output_a_oe != $past(reg_wdata[0]))
		else $error("output A open-drain drive wrong");
	chk_b_push_pull: assert property (wr12 && reg_wdata[6:5] == 2'b00
		&& !shared_pin_function |=> ext_clock_pin_oe
		&& ext_clock_pin_out == $past(reg_wdata[4]))
		else $error("output B push-pull level wrong");
	chk_clock_in_oe: assert property (shared_pin_function
		|-> !ext_clock_pin_oe) else $error("shared pin driven as clock input");
	chk_config_pins: assert property (reg_we && reg_addr == 8'h13
		|=> {shared_pin_function, shared_pin_pulldown, enable_pin_pulldown,
		thermal_warn_threshold, spread_spectrum_on} == $past(reg_wdata[4:0]))
		else $error("config pins do not follow write");
	chk_reserved_zero: assert property (reg_addr == 8'h12
		|=> (reg_rdata & 8'h88) == 8'h00) else $error("reserved bits set");
	chk_regb_rise: assert property ($rose(linear_reg_b_en)
		|-> $past(enable_pin, 3)) else $error("regulator on without enable");
	chk_regb_fall: assert property ($fell(linear_reg_b_en)
		|-> !$past(enable_pin, 3)) else $error("regulator off with enable");
	chk_a_rise_cause: assert property ($rose(general_output_a_out)
		&& !$past(reg_we) |-> $past(enable_pin, 3))
		else $error("output A rose without cause");
endmodule
bind esoc_top esoc_chk i_esoc_chk (.*);

// ---- bench/esoc_bench.sv ----
// Purpose: Directed register and sequencing tests for esoc_top.
// Assumes: STEP_CYCLES cut to 4 so the longest delay is 120 cycles.
// Notes:   Delays are counted in falling edges after the pin moves.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
$display("ERROR %0t got %h exp %h", $time, g, e); end end
module esoc_bench;
	localparam int STEP = 4;
	int failures = 0, n_checks = 0;
	logic mclk = 0, rst_n = 0, en_req = 0, reg_we = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	wire [7:0] reg_rdata;
	wire enable_pin, regb, a_out, a_oe, b_out, b_oe, fn, spd, enpd, thr, ss;
	wire [9:0] outs = {regb, a_out, a_oe, b_out, b_oe, fn, spd, enpd, thr, ss};
	esoc_top #(.STEP_CYCLES(STEP)) i_esoc_top (.mclk(mclk), .rst_n(rst_n),
		.enable_pin(enable_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_rdata(reg_rdata), .linear_reg_b_en(regb),
		.general_output_a_out(a_out), .general_output_a_oe(a_oe),
		.ext_clock_pin_out(b_out), .ext_clock_pin_oe(b_oe),
		.shared_pin_function(fn), .shared_pin_pulldown(spd),
		.enable_pin_pulldown(enpd), .thermal_warn_threshold(thr),
		.spread_spectrum_on(ss));
	esoc_host i_esoc_host (.level(en_req), .enable_pin(enable_pin));
	initial
	begin
		forever #2 mclk = ~mclk;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1;
		@(negedge mclk);
		reg_we = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_addr = a;
		@(negedge mclk);
		`CHK(reg_rdata, e)
	endtask
	task automatic seq(input logic lvl, input int e0, input int e1,
		input int e2);
		int t0 = -1, t1 = -1, t2 = -1;
		@(negedge mclk);
		en_req = lvl;
		for (int i = 1; i <= 200; i++)
		begin
			@(negedge mclk);
			if (t0 < 0 && regb === lvl) t0 = i;
			if (t1 < 0 && a_out === lvl) t1 = i;
			if (t2 < 0 && b_out === lvl) t2 = i;
		end
		`CHK(t0, e0)
		`CHK(t1, e1)
		`CHK(t2, e2)
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		logic [7:0] rv [5] = '{8'h00, 8'h05, 8'h0A, 8'h77, 8'h06};
		int on, off;
		repeat (3) @(negedge mclk);
		rst_n = 1;
		`CHK(outs, 10'h0A6)
		for (int i = 0; i < 5; i++)
			rd(8'(8'h0F + i), rv[i]);
		rd(8'h20, 8'h00);
		wr(8'h12, 8'hFF);
		rd(8'h12, 8'h77);
		wr(8'h12, 8'h01);
		`CHK(outs, 10'h1A6)
		wr(8'h12, 8'h05);
		`CHK(outs, 10'h026)
		wr(8'h13, 8'h1F);
		`CHK(outs, 10'h01F)
		wr(8'h13, 8'h00);
		`CHK(outs, 10'h020)
		wr(8'h0F, 8'h21);
		wr(8'h10, 8'h0F);
		wr(8'h11, 8'hF0);
		wr(8'h12, 8'h33);
		for (int k = 0; k < 2; k++)
		begin
			wr(8'h13, k ? 8'h26 : 8'h46);
			on = k ? STEP : 2 * STEP;
			off = k ? 2 * STEP : STEP;
			seq(1, 3 + on, 3 + 15 * on, 3);
			seq(0, 3 + 2 * off, 3, 3 + 15 * off);
		end
		tally_and_finish();
	end
endmodule
